// >>> hw/uatx_tx.sv
// Asynchronous serial transmitter with break generation
`default_nettype none
// ******************************
// Transmitter
// ******************************
module uatx_tx (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_transmit_enable,
	input  wire logic        i_sync_mode,
	input  wire logic        i_serial_port_enable,
	input  wire logic        i_output_polarity_invert,
	input  wire logic        i_tx_interrupt_enable,
	input  wire logic        i_send_break_set,
	input  wire logic        i_nine_bit_mode,
	input  wire logic        i_ninth_bit,
	input  wire logic        i_baud_16bit,
	input  wire logic [15:0] i_baud_divisor,
	input  wire logic        i_wr_valid,
	input  wire logic [7:0]  i_wr_data,
	output logic             o_wr_ready,
	output logic             o_tx_buffer_empty_flag,
	output logic             o_tx_irq,
	output logic             o_shift_register_empty_status,
	output logic             o_send_break_request,
	output logic             o_tx_out,
	output logic             o_tx_oe
);
	localparam int W = uatx_pkg::WORD_W;

	uatx_pkg::uatx_state_t       state_q;
	logic [uatx_pkg::BAUD_W-1:0] cnt_q;
	logic [uatx_pkg::BAUD_W-1:0] period;
	logic                        baud_tick;
	logic                        active;
	logic [11:0]                 shreg_q;
	logic [3:0]                  bit_cnt_q;
	logic [3:0]                  nbits_q;
	logic                        brk_q;
	logic                        line_q;
	logic                        oe_q;
	logic                        send_break_q;
	logic                        armed_q;
	logic                        break_done;
	logic [uatx_pkg::FLAG_DELAY-1:0] flag_pipe_q;
	logic                        flag_raw;
	logic                        irq_q;
	logic                        in_ready;
	logic                        push;
	logic [W-1:0]                push_word;
	logic                        q_valid;
	logic [W-1:0]                q_word;
	logic                        load;
	logic                        can_load;

	// ******************************
	// Enable and holding buffer
	// ******************************
	assign active     = i_transmit_enable && !i_sync_mode && i_serial_port_enable;
	assign o_wr_ready = in_ready && active;
	assign push       = i_wr_valid && o_wr_ready;

	// Break word carries no data, so written bits are dropped here
	always_comb begin
		push_word = {1'b0, i_nine_bit_mode & i_ninth_bit, i_wr_data};
		if (send_break_q && !armed_q) begin
			push_word = '0;
			push_word[uatx_pkg::WORD_BRK] = 1'b1;
		end
	end

	// Disabling flushes the queue, so re-enabling starts with an empty buffer
	uatx_fifo #(
		.WIDTH (W),
		.DEPTH (uatx_pkg::FIFO_DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_flush     (!active),
		.i_in_valid  (push),
		.o_in_ready  (in_ready),
		.i_in_data   (push_word),
		.o_out_valid (q_valid),
		.i_out_ready (load),
		.o_out_data  (q_word)
	);

	// ******************************
	// Baud timing
	// ******************************
	assign period    = i_baud_16bit ? i_baud_divisor : {8'h00, i_baud_divisor[7:0]};
	assign baud_tick = (state_q != uatx_pkg::ST_IDLE) && (cnt_q == period);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q <= uatx_pkg::BAUD_RST;
		end else if (load || baud_tick || state_q == uatx_pkg::ST_IDLE) begin
			cnt_q <= uatx_pkg::BAUD_RST;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	// ******************************
	// Shifter sequence
	// ******************************
	assign can_load = (state_q == uatx_pkg::ST_IDLE)
		|| (state_q == uatx_pkg::ST_STOP && baud_tick);
	assign load     = active && q_valid && can_load;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= uatx_pkg::ST_IDLE;
		end else if (!active) begin
			state_q <= uatx_pkg::ST_IDLE;
		end else if (load) begin
			state_q <= uatx_pkg::ST_START;
		end else if (baud_tick) begin
			unique case (state_q)
				uatx_pkg::ST_START: begin
					state_q <= uatx_pkg::ST_DATA;
				end
				uatx_pkg::ST_DATA: begin
					if (bit_cnt_q == nbits_q - 4'h1) begin
						state_q <= uatx_pkg::ST_STOP;
					end
				end
				uatx_pkg::ST_STOP: begin
					state_q <= uatx_pkg::ST_IDLE;
				end
				uatx_pkg::ST_IDLE: begin
					state_q <= uatx_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Shift register has no software path; only the queue loads it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			shreg_q   <= 12'h000;
			bit_cnt_q <= 4'h0;
			nbits_q   <= uatx_pkg::BITS_EIGHT;
			brk_q     <= 1'b0;
		end else if (load) begin
			shreg_q   <= {3'h0, q_word[uatx_pkg::WORD_NINTH:0]};
			bit_cnt_q <= 4'h0;
			brk_q     <= q_word[uatx_pkg::WORD_BRK];
			if (q_word[uatx_pkg::WORD_BRK]) begin
				shreg_q <= 12'h000;
				nbits_q <= uatx_pkg::BITS_BREAK;
			end else if (i_nine_bit_mode) begin
				nbits_q <= uatx_pkg::BITS_NINE;
			end else begin
				nbits_q <= uatx_pkg::BITS_EIGHT;
			end
		end else if (baud_tick && state_q == uatx_pkg::ST_DATA) begin
			shreg_q   <= {1'b0, shreg_q[11:1]};
			bit_cnt_q <= bit_cnt_q + 4'h1;
		end
	end

	// ******************************
	// Line driver
	// ******************************
	// Line is registered so the pin never glitches between bits
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			line_q <= uatx_pkg::LINE_MARK;
		end else if (load) begin
			line_q <= uatx_pkg::LINE_SPACE;
		end else if (baud_tick && state_q == uatx_pkg::ST_START) begin
			line_q <= shreg_q[0];
		end else if (baud_tick && state_q == uatx_pkg::ST_DATA) begin
			if (bit_cnt_q == nbits_q - 4'h1) begin
				line_q <= uatx_pkg::LINE_MARK;
			end else begin
				line_q <= shreg_q[1];
			end
		end else if (!active || state_q == uatx_pkg::ST_IDLE) begin
			line_q <= uatx_pkg::LINE_MARK;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= i_serial_port_enable;
		end
	end

	assign o_tx_out = line_q ^ (i_output_polarity_invert && !i_sync_mode);
	assign o_tx_oe  = oe_q;
	assign o_shift_register_empty_status = state_q == uatx_pkg::ST_IDLE;

	// ******************************
	// Break request
	// ******************************
	assign break_done = baud_tick && state_q == uatx_pkg::ST_STOP && brk_q;

	// A fresh request in the clearing cycle wins
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			send_break_q <= 1'b0;
			armed_q      <= 1'b0;
		end else begin
			if (i_send_break_set) begin
				send_break_q <= 1'b1;
			end else if (break_done || !i_transmit_enable) begin
				send_break_q <= 1'b0;
			end
			if (i_send_break_set && !send_break_q) begin
				armed_q <= 1'b0;
			end else if (push && send_break_q && !armed_q) begin
				armed_q <= 1'b1;
			end else if (break_done) begin
				armed_q <= 1'b0;
			end
		end
	end

	assign o_send_break_request = send_break_q;

	// ******************************
	// Buffer-empty flag and request
	// ******************************
	// Queued means waiting behind a busy shifter; an idle shifter takes it in the same cycle
	assign flag_raw = active && (!q_valid || state_q == uatx_pkg::ST_IDLE);

	// Two-stage delay; no software path reaches it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			flag_pipe_q <= '0;
		end else begin
			flag_pipe_q <= {flag_pipe_q[uatx_pkg::FLAG_DELAY-2:0], flag_raw};
		end
	end

	assign o_tx_buffer_empty_flag = flag_pipe_q[uatx_pkg::FLAG_DELAY-1];

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= flag_pipe_q[uatx_pkg::FLAG_DELAY-2] && i_tx_interrupt_enable;
		end
	end

	assign o_tx_irq = irq_q;

	// ******************************
	// Checks
	// ******************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	start_space_a: assert property (
		load |=> (line_q == uatx_pkg::LINE_SPACE) && (state_q == uatx_pkg::ST_START))
		else $error("start bit not at space");

	lsb_first_a: assert property (
		(baud_tick && state_q == uatx_pkg::ST_START) |=> line_q == $past(shreg_q[0]))
		else $error("first data bit not lsb");

	bit_len_a: assert property (
		(load && period == 16'h0003) |=> (state_q == uatx_pkg::ST_START) [*4] ##1
		(state_q != uatx_pkg::ST_START))
		else $error("bit period wrong");

	inactive_idle_a: assert property (
		!active |-> !o_wr_ready ##1 (state_q == uatx_pkg::ST_IDLE && !q_valid))
		else $error("shifting while disabled");

	pin_drive_a: assert property (
		i_serial_port_enable |=> o_tx_oe)
		else $error("pin not driven after port enable");

	idle_first_load_a: assert property (
		(push && state_q == uatx_pkg::ST_IDLE && !q_valid) |=> ##1 state_q == uatx_pkg::ST_START)
		else $error("write to idle shifter did not start");

	stop_to_start_a: assert property (
		(state_q == uatx_pkg::ST_STOP && baud_tick && active && q_valid)
		|=> state_q == uatx_pkg::ST_START && line_q == uatx_pkg::LINE_SPACE)
		else $error("queued character not sent after stop");

	idle_level_a: assert property (
		(oe_q && state_q == uatx_pkg::ST_IDLE && $past(state_q) == uatx_pkg::ST_IDLE && !i_sync_mode)
		|-> o_tx_out == !i_output_polarity_invert)
		else $error("idle level wrong");

	flag_delay_a: assert property (
		!$past(i_rst, 2) |-> o_tx_buffer_empty_flag == $past(flag_raw, 2))
		else $error("empty flag timing wrong");

	enable_flag_a: assert property (
		$rose(active) |-> ##2 o_tx_buffer_empty_flag)
		else $error("empty flag not set on enable");

	irq_gate_a: assert property (
		o_tx_irq |-> $past(i_tx_interrupt_enable) && o_tx_buffer_empty_flag)
		else $error("request without its enable");

	break_zero_a: assert property (
		(brk_q && state_q == uatx_pkg::ST_DATA) |-> line_q == uatx_pkg::LINE_SPACE)
		else $error("break data not zero");

	break_clear_a: assert property (
		(break_done && !i_send_break_set) |=> !send_break_q)
		else $error("break request not cleared");

	one_stop_a: assert property (
		(state_q == uatx_pkg::ST_STOP && baud_tick) |=> state_q != uatx_pkg::ST_STOP)
		else $error("more than one stop bit");

	break_frame_c: cover property (break_done ##[0:40] load);
	nine_bit_c:    cover property (load && i_nine_bit_mode);
	back_to_back_c: cover property (state_q == uatx_pkg::ST_STOP && baud_tick && load);
	invert_c:      cover property (load && i_output_polarity_invert);
endmodule
`default_nettype wire

// >>> hw/uatx_pkg.sv
// Shared constants and types of the asynchronous serial transmitter
`default_nettype none
package uatx_pkg;
	// ******************************
	// Widths and depths
	// ******************************
	localparam int          DATA_W      = 8;
	localparam int          WORD_W      = 10;
	localparam int          FIFO_DEPTH  = 32;
	localparam int          BAUD_W      = 16;
	localparam int          CNT_W       = 4;
	localparam int          FLAG_DELAY  = 2;
	// ******************************
	// Queued word layout
	// ******************************
	localparam int          WORD_BRK    = 9;
	localparam int          WORD_NINTH  = 8;
	// ******************************
	// Frame lengths and levels
	// ******************************
	localparam logic [3:0]  BITS_EIGHT  = 4'h8;
	localparam logic [3:0]  BITS_NINE   = 4'h9;
	localparam logic [3:0]  BITS_BREAK  = 4'hC;
	localparam logic        LINE_MARK   = 1'b1;
	localparam logic        LINE_SPACE  = 1'b0;
	localparam logic [15:0] BAUD_RST    = 16'h0000;
	// ******************************
	// Types
	// ******************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_DATA,
		ST_STOP
	} uatx_state_t;
endpackage
`default_nettype wire

// >>> hw/uatx_fifo.sv
// Parameterised FIFO with valid/ready on both sides and a flush
`default_nettype none
module uatx_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_flush,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	logic             push;
	logic             pop;

	assign o_in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign o_out_valid = wr_q != rd_q;
	assign o_out_data  = mem_q[rd_q[AW-1:0]];
	assign push        = i_in_valid && o_in_ready && !i_flush;
	assign pop         = o_out_valid && i_out_ready && !i_flush;

	// ******************************
	// Storage has no reset; pointers guard it
	// ******************************
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= i_in_data;
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (i_flush) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + (AW+1)'(1);
			end
			if (pop) begin
				rd_q <= rd_q + (AW+1)'(1);
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/uatx_rx_model.sv
// Behavioural model of the remote asynchronous receiver watching the line
`default_nettype none
module uatx_rx_model (
	input  wire logic        i_clk,
	input  wire logic        i_line,
	input  wire logic        i_invert,
	input  wire logic [16:0] i_period,
	input  wire logic [3:0]  i_nbits,
	output logic             o_valid,
	output logic [11:0]      o_data,
	output logic             o_stop,
	output logic [15:0]      o_span
);
	timeunit 1ns;
	timeprecision 1ps;
	// ******************************
	// Frame decoder
	// ******************************
	// Samples at mid bit; span is start-to-start, so a lost idle clock shows up
	logic        ln;
	logic        busy  = 1'b0;
	logic [11:0] sh    = 12'h000;
	logic [15:0] since = 16'h0000;
	int          pos   = 0;
	assign ln = i_line ^ i_invert;
	initial o_valid = 1'b0;
	always @(posedge i_clk) begin
		int k;
		int p;
		p = int'(i_period);
		o_valid <= 1'b0;
		if (since != 16'hFFFF) since <= since + 16'h0001;
		if (!busy && ln === 1'b0) begin
			busy   <= 1'b1;
			pos    <= 1;
			sh     <= 12'h000;
			o_span <= since;
			since  <= 16'h0001;
		end else if (busy) begin
			pos <= pos + 1;
			if (pos % p == p / 2) begin
				k = pos / p;
				if (k == 0 && ln !== 1'b0) busy <= 1'b0;
				else if (k >= 1 && k <= int'(i_nbits)) sh[k-1] <= ln;
				else if (k == int'(i_nbits) + 1) begin
					busy    <= 1'b0;
					o_valid <= 1'b1;
					o_stop  <= ln;
					o_data  <= sh;
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
// Self-checking bench of the asynchronous serial transmitter
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_clk = 1'b0, i_rst = 1'b1, i_transmit_enable = 1'b1, i_sync_mode = 1'b0;
	logic        i_serial_port_enable = 1'b1, i_output_polarity_invert = 1'b0;
	logic        i_tx_interrupt_enable = 1'b0, i_send_break_set = 1'b0;
	logic        i_nine_bit_mode = 1'b0, i_ninth_bit = 1'b0, i_baud_16bit = 1'b0;
	logic [15:0] i_baud_divisor = 16'h5A03;
	logic        i_wr_valid = 1'b0;
	logic [7:0]  i_wr_data = 8'h00;
	logic        o_wr_ready, o_tx_buffer_empty_flag, o_tx_irq, o_shift_register_empty_status;
	logic        o_send_break_request, o_tx_out, o_tx_oe, rx_valid, rx_stop;
	logic [11:0] rx_data;
	logic [15:0] rx_span;
	logic [3:0]  rx_bits = 4'h8, base_bits = 4'h8;
	logic [16:0] period = 17'h00004;
	logic [28:0] rx_q[$];
	int          error_cnt = 0, num_checks = 0, cycles = 0;

	always #2.5 i_clk = ~i_clk;

	uatx_tx i_uatx_tx (.i_clk(i_clk), .i_rst(i_rst), .i_transmit_enable(i_transmit_enable),
		.i_sync_mode(i_sync_mode), .i_serial_port_enable(i_serial_port_enable),
		.i_output_polarity_invert(i_output_polarity_invert),
		.i_tx_interrupt_enable(i_tx_interrupt_enable), .i_send_break_set(i_send_break_set),
		.i_nine_bit_mode(i_nine_bit_mode), .i_ninth_bit(i_ninth_bit),
		.i_baud_16bit(i_baud_16bit), .i_baud_divisor(i_baud_divisor),
		.i_wr_valid(i_wr_valid), .i_wr_data(i_wr_data), .o_wr_ready(o_wr_ready),
		.o_tx_buffer_empty_flag(o_tx_buffer_empty_flag), .o_tx_irq(o_tx_irq),
		.o_shift_register_empty_status(o_shift_register_empty_status),
		.o_send_break_request(o_send_break_request), .o_tx_out(o_tx_out), .o_tx_oe(o_tx_oe));

	uatx_rx_model i_uatx_rx_model (.i_clk(i_clk), .i_line(o_tx_out),
		.i_invert(i_output_polarity_invert), .i_period(period), .i_nbits(rx_bits),
		.o_valid(rx_valid), .o_data(rx_data), .o_stop(rx_stop), .o_span(rx_span));

	// ******************************
	// Tasks
	// ******************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	// Holds the request until ready is seen, so a refused write is simply retried
	task automatic wr(input logic [7:0] d, input logic n9);
		i_wr_data   <= d;
		i_ninth_bit <= n9;
		i_wr_valid  <= 1'b1;
		@(negedge i_clk);
		for (int k = 0; k < 4000 && o_wr_ready !== 1'b1; k++) @(negedge i_clk);
		@(posedge i_clk);
	endtask
	task automatic wr_end();
		i_wr_valid <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rx_expect(input logic [11:0] d, input logic [15:0] span);
		logic [28:0] e;
		for (int k = 0; k < 4000 && rx_q.size() == 0; k++) @(posedge i_clk);
		check(16'(rx_q.size() != 0), 16'h0001);
		if (rx_q.size() != 0) begin
			e = rx_q.pop_front();
			check({4'h0, e[11:0]}, {4'h0, d});
			check(16'(e[28]), 16'h0001);
			if (span != 16'h0000) check(e[27:12], span);
		end
	endtask
	task automatic final_report();
		$display("Checks %0d, errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	always @(posedge i_clk) begin
		if (rx_valid) begin
			rx_q.push_back({rx_stop, rx_span, rx_data});
			if (rx_bits == 4'hC) rx_bits <= base_bits;
		end
	end
	// Whole run needs under 5000 cycles; a hang is cut well after that
	always @(posedge i_clk) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			final_report();
		end
	end

	// ******************************
	// Sequence
	// ******************************
	initial begin
		cyc(3);
		@(negedge i_clk);
		check({o_tx_out, o_shift_register_empty_status, o_tx_oe, o_tx_buffer_empty_flag},
			16'h000C);
		@(posedge i_clk);
		cyc(1);
		i_rst <= 1'b0;
		cyc(4);
		@(negedge i_clk);
		check(16'(o_tx_buffer_empty_flag), 16'h0001);
		check(16'(o_tx_oe), 16'h0001);
		@(posedge i_clk);
		// Low byte only in 8-bit divider mode: period 4 clocks
		wr(8'hA5, 1'b0);
		wr_end();
		cyc(1);
		@(negedge i_clk);
		check(16'(o_shift_register_empty_status), 16'h0000);
		rx_expect(12'h0A5, 16'h0000);
		cyc(4);
		i_baud_16bit   <= 1'b1;
		i_baud_divisor <= 16'h0007;
		period = 17'h00008;
		i_tx_interrupt_enable <= 1'b1;
		cyc(1);
		for (int k = 0; k < 33; k++) wr(8'(k * 7 + 3), 1'b0);
		wr_end();
		@(negedge i_clk);
		check(16'(o_wr_ready), 16'h0000);
		check(16'(o_tx_buffer_empty_flag), 16'h0000);
		check(16'(o_tx_irq), 16'h0000);
		for (int k = 0; k < 33; k++)
			rx_expect({4'h0, 8'(k * 7 + 3)}, (k == 0) ? 16'h0000 : 16'h0050);
		cyc(8);
		@(negedge i_clk);
		check(16'(o_tx_buffer_empty_flag), 16'h0001);
		check(16'(o_tx_irq), 16'h0001);
		check(16'(o_shift_register_empty_status), 16'h0001);
		@(posedge i_clk);
		i_tx_interrupt_enable <= 1'b0;
		i_output_polarity_invert <= 1'b1;
		cyc(3);
		@(negedge i_clk);
		check({o_tx_irq, o_tx_buffer_empty_flag}, 16'h0001);
		check(16'(o_tx_out), 16'h0000);
		@(posedge i_clk);
		wr(8'h96, 1'b0);
		wr_end();
		rx_expect(12'h096, 16'h0000);
		cyc(4);
		i_output_polarity_invert <= 1'b0;
		i_nine_bit_mode <= 1'b1;
		rx_bits = 4'h9;
		base_bits = 4'h9;
		wr(8'h5A, 1'b1);
		wr(8'hFF, 1'b0);
		wr_end();
		rx_expect(12'h15A, 16'h0000);
		rx_expect(12'h0FF, 16'h0058);
		cyc(4);
		i_nine_bit_mode <= 1'b0;
		rx_bits = 4'h8;
		base_bits = 4'h8;
		i_send_break_set <= 1'b1;
		@(posedge i_clk);
		i_send_break_set <= 1'b0;
		@(negedge i_clk);
		check(16'(o_send_break_request), 16'h0001);
		@(posedge i_clk);
		rx_bits = 4'hC;
		wr(8'hFF, 1'b0);
		wr(8'h55, 1'b0);
		wr_end();
		@(negedge i_clk);
		check({o_shift_register_empty_status, o_send_break_request}, 16'h0001);
		rx_expect(12'h000, 16'h0000);
		rx_expect(12'h055, 16'h0070);
		check(16'(o_send_break_request), 16'h0000);
		cyc(4);
		i_transmit_enable <= 1'b0;
		cyc(3);
		@(negedge i_clk);
		check({o_wr_ready, o_tx_buffer_empty_flag}, 16'h0000);
		@(posedge i_clk);
		i_transmit_enable <= 1'b1;
		i_sync_mode <= 1'b1;
		cyc(3);
		@(negedge i_clk);
		check(16'(o_wr_ready), 16'h0000);
		@(posedge i_clk);
		i_sync_mode <= 1'b0;
		i_serial_port_enable <= 1'b0;
		cyc(3);
		@(negedge i_clk);
		check({o_wr_ready, o_tx_oe}, 16'h0000);
		@(posedge i_clk);
		i_serial_port_enable <= 1'b1;
		cyc(4);
		@(negedge i_clk);
		check({o_wr_ready, o_tx_oe, o_tx_buffer_empty_flag}, 16'h0007);
		final_report();
	end
endmodule
`default_nettype wire
